/* File: adcsp_regs.svh */
// Constants for the serial port, interrupt pin and clock tree.
// Assumes inclusion by bare name; definitions only.
`ifndef ADCSP_REGS_SVH
`define ADCSP_REGS_SVH

// Clock rates
`define ADCSP_REF_CLK_HZ 125000000
`define ADCSP_INT_OSC_HZ 4915200
`define ADCSP_INT_HALF_CYC (`ADCSP_REF_CLK_HZ / (2 * `ADCSP_INT_OSC_HZ))

// Command byte fields
`define ADCSP_CMD_ADDR_MSB 7
`define ADCSP_CMD_ADDR_LSB 6
`define ADCSP_CMD_TYPE_MSB 1
`define ADCSP_CMD_TYPE_LSB 0
`define ADCSP_CMD_FAST 2'h0
`define ADCSP_CMD_SREAD 2'h1
`define ADCSP_CMD_WRITE 2'h2
`define ADCSP_CMD_IREAD 2'h3

// Interrupt pin mode field bits
`define ADCSP_IRQM_FUNC_BIT 1
`define ADCSP_IRQM_IDLE_BIT 0

// Interrupt source positions
`define ADCSP_IRQ_DRDY 0
`define ADCSP_IRQ_CRC 1
`define ADCSP_IRQ_POR 2
`define ADCSP_IRQ_AUX 3

// Clock select
`define ADCSP_CLKSEL_INT_BIT 1
`define ADCSP_CLKSEL_OUT 2'h3

// Divider figures and reset values
`define ADCSP_ANALOG_MASTER_CLOCK_PER_SAMPLE 4
`define ADCSP_SDO_RST 1'b0
`define ADCSP_SYNC_RST 4'h9

`endif

/* File: adcsp_pkg.sv */
// Types shared by the serial port and clock tree modules.
// Assumes nothing of its surroundings.
package adcsp_pkg;

  typedef enum logic [2:0] {
    SPI_IDLE = 3'b000,
    SPI_CMD = 3'b001,
    SPI_READ = 3'b010,
    SPI_WRITE = 3'b011,
    SPI_DROP = 3'b100
  } adcsp_spi_state_e;

  typedef logic [7:0] adcsp_byte_t;

endpackage

/* File: adcsp_clk_if.sv */
// Clock tree ticks passed from the divider chain to the top.
// Assumes one reference clock for all users.
`timescale 1ns/10ps
interface adcsp_clk_if;
  logic analog_master_clock_level;
  logic analog_master_clock_rise;
  logic sample_tick;
  logic rate_tick;
  modport src (output analog_master_clock_level, output analog_master_clock_rise, output sample_tick, output rate_tick);
  modport snk (input analog_master_clock_level, input analog_master_clock_rise, input sample_tick, input rate_tick);
endinterface

/* File: adcsp_sync.sv */
// Two-stage synchroniser, one chain per bit.
// Assumes inputs asynchronous to i_ref_clk.
`timescale 1ns/10ps
module adcsp_sync import adcsp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_reg;
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta_reg <= RST[gi];
          o_sync[gi] <= RST[gi];
        end else begin
          meta_reg <= i_async[gi];
          o_sync[gi] <= meta_reg;
        end
      end
    end
  endgenerate
endmodule

/* File: adcsp_clk_tree.sv */
// Master clock selection, prescaler, sample and output rate dividers.
// Assumes the master clock pin is asynchronous and slower than half i_ref_clk.
`timescale 1ns/10ps
`include "adcsp_regs.svh"
module adcsp_clk_tree import adcsp_pkg::*; #(
  parameter int OSR_W = 17,
  parameter int INT_HALF = `ADCSP_INT_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_mclk_pin,
  input wire logic [1:0] i_clk_sel,
  input wire logic [1:0] i_prescale_sel,
  input wire logic [OSR_W-1:0] i_osr,
  input wire logic i_continuous,
  adcsp_clk_if.src ck
);
  logic mclk_s;
  logic mclk_d_reg;
  logic [7:0] osc_cnt_reg;
  logic int_edge;
  logic master_edge;
  logic [2:0] pre_cnt_reg;
  logic [2:0] pre_max;
  logic pre_wrap;
  logic [1:0] smp_cnt_reg;
  logic [OSR_W-1:0] osr_cnt_reg;
  logic [OSR_W-1:0] osr_max;
  logic [2:0] rise_cnt_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  adcsp_sync #(.W(1), .RST(1'b0)) u_mclk_sync (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_mclk_pin),
    .o_sync(mclk_s)
  );

  assign int_edge = (osc_cnt_reg == 8'(INT_HALF - 1));
  assign master_edge = i_clk_sel[`ADCSP_CLKSEL_INT_BIT] ? int_edge : (mclk_s ^ mclk_d_reg);
  assign pre_max = 3'((4'h1 << i_prescale_sel) - 4'h1);
  assign pre_wrap = master_edge && (pre_cnt_reg >= pre_max);
  assign osr_max = (i_osr == '0) ? '0 : i_osr - 1'b1;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mclk_d_reg <= 1'b0;
      osc_cnt_reg <= 8'h00;
    end else begin
      mclk_d_reg <= mclk_s;
      osc_cnt_reg <= int_edge ? 8'h00 : osc_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt_reg <= 3'h0;
      ck.analog_master_clock_level <= 1'b0;
      ck.analog_master_clock_rise <= 1'b0;
    end else begin
      ck.analog_master_clock_rise <= pre_wrap && !ck.analog_master_clock_level;
      if (pre_wrap) begin
        pre_cnt_reg <= 3'h0;
        ck.analog_master_clock_level <= !ck.analog_master_clock_level;
      end else if (master_edge) begin
        pre_cnt_reg <= pre_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      smp_cnt_reg <= 2'h0;
      ck.sample_tick <= 1'b0;
    end else begin
      ck.sample_tick <= ck.analog_master_clock_rise && (smp_cnt_reg == 2'(`ADCSP_ANALOG_MASTER_CLOCK_PER_SAMPLE - 1));
      if (ck.analog_master_clock_rise) begin
        smp_cnt_reg <= smp_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      osr_cnt_reg <= '0;
      ck.rate_tick <= 1'b0;
    end else begin
      ck.rate_tick <= i_continuous && ck.sample_tick && (osr_cnt_reg >= osr_max);
      if (!i_continuous) begin
        osr_cnt_reg <= '0;
      end else if (ck.sample_tick) begin
        osr_cnt_reg <= (osr_cnt_reg >= osr_max) ? '0 : osr_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_cnt_reg <= 3'h0;
    end else if (ck.sample_tick) begin
      rise_cnt_reg <= {2'h0, ck.analog_master_clock_rise};
    end else if (ck.analog_master_clock_rise) begin
      rise_cnt_reg <= rise_cnt_reg + 3'h1;
    end
  end

  property p_analog_master_clock_on_master;
    $changed(ck.analog_master_clock_level) |-> $past(master_edge);
  endproperty
  a_analog_master_clock_on_master: assert property (p_analog_master_clock_on_master) else $error("analog clock moved without master edge");

  property p_sample_div4;
    ck.sample_tick |-> (rise_cnt_reg == 3'h4);
  endproperty
  a_sample_div4: assert property (p_sample_div4) else $error("sample tick not after four analog rises");

  property p_rate_after_sample;
    ck.rate_tick |-> ($past(ck.sample_tick) && $past(i_continuous));
  endproperty
  a_rate_after_sample: assert property (p_rate_after_sample) else $error("rate tick without sample tick");
endmodule

/* File: adcsp_top.sv */
// Serial slave port, shared interrupt/modulator pin and clock pin of the converter.
// Assumes SPI and master clock pins asynchronous to i_ref_clk; SCK below a third of it.
`timescale 1ns/10ps
`include "adcsp_regs.svh"
// Notes on behaviour
// - Chip select fall starts, rise ends transfer
// - Chip select high ignores clock and data
// - Sample input on rise, launch on fall
// - Clock modes 0,0 and 1,1 both work
// - Serial and master clocks are asynchronous
// - Output released when deselected, writes, fast commands
// - Address mismatch releases output after two bits
// - Input data ignored during register reads
// - Mode upper bit picks interrupt or bitstream
// - Any of four interrupts drives pin low
// - Mode lower bit picks idle release or high
// - Bitstream mode outputs modulator bits per sample
// - Reset and CRC interrupts override bitstream output
// - Pin level is sensed back, expects high
// - Clock select decides clock pin direction
// - Master clock from pin or internal oscillator
// - Analog clock is master clock over prescale
// - Sample clock is analog clock over four
// - Results at sample rate over oversampling ratio
// - Each new result gives data ready pulse
module adcsp_top import adcsp_pkg::*; #(
  parameter int OSR_W = 17,
  parameter int INT_HALF = `ADCSP_INT_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  input wire logic i_irq_pin,
  output logic o_irq_pin,
  output logic o_irq_oe,
  input wire logic i_mclk_pin,
  output logic o_mclk_pin,
  output logic o_mclk_oe,
  input wire logic [1:0] i_irq_mode,
  input wire logic [1:0] i_clk_sel,
  input wire logic [1:0] i_prescale_sel,
  input wire logic [OSR_W-1:0] i_osr,
  input wire logic i_continuous,
  input wire logic [1:0] i_chip_addr,
  input wire logic [7:0] i_status,
  input wire logic [7:0] i_rd_data,
  input wire logic i_mod_bit,
  input wire logic i_por_event,
  input wire logic i_crc_event,
  input wire logic i_aux_event,
  input wire logic [3:0] i_irq_clr,
  output logic [7:0] o_cmd,
  output logic o_cmd_valid,
  output logic [7:0] o_wr_data,
  output logic o_wr_valid,
  output logic o_rd_req,
  output logic o_spi_busy,
  output logic [3:0] o_irq_pending,
  output logic o_irq_line_high,
  output logic o_irq_line_fault,
  output logic o_sample_tick,
  output logic o_result_tick
);
  logic [3:0] sync_q;
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic irq_s;
  logic cs_d_reg;
  logic sck_d_reg;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  adcsp_spi_state_e state_reg;
  logic [2:0] bit_cnt_reg;
  adcsp_byte_t rx_reg;
  adcsp_byte_t tx_reg;
  adcsp_byte_t rx_full;
  logic skip_reg;
  logic addr_bad_reg;
  logic [3:0] irq_set;
  logic [3:0] irq_clr_eff;
  logic mod_reg;
  logic irq_pin_next;
  logic irq_oe_next;
  logic [2:0] low_hist_reg;

  adcsp_clk_if ck ();

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  adcsp_sync #(.W(4), .RST(`ADCSP_SYNC_RST)) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_irq_pin, i_sdi, i_sck, i_cs_n}),
    .o_sync(sync_q)
  );

  adcsp_clk_tree #(.OSR_W(OSR_W), .INT_HALF(INT_HALF)) u_clk_tree (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_mclk_pin(i_mclk_pin),
    .i_clk_sel(i_clk_sel),
    .i_prescale_sel(i_prescale_sel),
    .i_osr(i_osr),
    .i_continuous(i_continuous),
    .ck(ck)
  );

  assign cs_s = sync_q[0];
  assign sck_s = sync_q[1];
  assign sdi_s = sync_q[2];
  assign irq_s = sync_q[3];

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
    end else begin
      cs_d_reg <= cs_s;
      sck_d_reg <= sck_s;
    end
  end

  assign cs_fall = cs_d_reg && !cs_s;
  assign cs_rise = !cs_d_reg && cs_s;
  assign sck_rise = !sck_d_reg && sck_s && !cs_s;
  assign sck_fall = sck_d_reg && !sck_s && !cs_s;
  assign rx_full = {rx_reg[6:0], sdi_s};

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= SPI_IDLE;
      bit_cnt_reg <= 3'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      skip_reg <= 1'b0;
      addr_bad_reg <= 1'b0;
      o_sdo <= `ADCSP_SDO_RST;
      o_sdo_oe <= 1'b0;
      o_cmd <= 8'h00;
      o_cmd_valid <= 1'b0;
      o_wr_data <= 8'h00;
      o_wr_valid <= 1'b0;
      o_rd_req <= 1'b0;
    end else begin
      o_cmd_valid <= 1'b0;
      o_wr_valid <= 1'b0;
      o_rd_req <= 1'b0;
      if (cs_rise) begin
        state_reg <= SPI_IDLE;
        o_sdo_oe <= 1'b0;
      end else if (cs_fall) begin
        state_reg <= SPI_CMD;
        bit_cnt_reg <= 3'h0;
        skip_reg <= sck_s;
        addr_bad_reg <= 1'b0;
        tx_reg <= i_status;
        o_sdo <= i_status[7];
        o_sdo_oe <= 1'b1;
      end else begin
        if (sck_rise && state_reg != SPI_IDLE) begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (state_reg != SPI_READ) begin
            rx_reg <= rx_full;
          end
          if (state_reg == SPI_CMD && bit_cnt_reg == 3'h1 && rx_full[1:0] != i_chip_addr) begin
            addr_bad_reg <= 1'b1;
            o_sdo_oe <= 1'b0;
          end
          if (state_reg == SPI_CMD && bit_cnt_reg == 3'h7) begin
            o_cmd <= rx_full;
            o_cmd_valid <= 1'b1;
            if (addr_bad_reg) begin
              state_reg <= SPI_DROP;
            end else begin
              case (rx_full[`ADCSP_CMD_TYPE_MSB:`ADCSP_CMD_TYPE_LSB])
                `ADCSP_CMD_SREAD, `ADCSP_CMD_IREAD: begin
                  state_reg <= SPI_READ;
                end
                `ADCSP_CMD_WRITE: begin
                  state_reg <= SPI_WRITE;
                  o_sdo_oe <= 1'b0;
                end
                default: begin
                  state_reg <= SPI_DROP;
                  o_sdo_oe <= 1'b0;
                end
              endcase
            end
          end
          if (state_reg == SPI_WRITE && bit_cnt_reg == 3'h7) begin
            o_wr_data <= rx_full;
            o_wr_valid <= 1'b1;
          end
        end
        if (sck_fall && state_reg != SPI_IDLE) begin
          if (skip_reg) begin
            skip_reg <= 1'b0;
          end else if (bit_cnt_reg == 3'h0) begin
            if (state_reg == SPI_READ) begin
              tx_reg <= i_rd_data;
              o_sdo <= i_rd_data[7];
              o_rd_req <= 1'b1;
            end
          end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            o_sdo <= tx_reg[6];
          end
        end
      end
    end
  end

  always_comb begin
    irq_set = 4'h0;
    irq_set[`ADCSP_IRQ_DRDY] = ck.rate_tick;
    irq_set[`ADCSP_IRQ_CRC] = i_crc_event;
    irq_set[`ADCSP_IRQ_POR] = i_por_event;
    irq_set[`ADCSP_IRQ_AUX] = i_aux_event;
    irq_clr_eff = i_irq_clr;
    irq_clr_eff[`ADCSP_IRQ_DRDY] = i_irq_clr[`ADCSP_IRQ_DRDY] | ck.sample_tick;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_pending <= 4'h0;
    end else begin
      o_irq_pending <= (o_irq_pending & ~irq_clr_eff) | irq_set;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mod_reg <= 1'b0;
    end else if (ck.sample_tick) begin
      mod_reg <= i_mod_bit;
    end
  end

  always_comb begin
    irq_pin_next = 1'b1;
    irq_oe_next = 1'b1;
    if (!i_irq_mode[`ADCSP_IRQM_FUNC_BIT]) begin
      if (|o_irq_pending) begin
        irq_pin_next = 1'b0;
      end else begin
        irq_oe_next = i_irq_mode[`ADCSP_IRQM_IDLE_BIT];
      end
    end else if (o_irq_pending[`ADCSP_IRQ_POR] || o_irq_pending[`ADCSP_IRQ_CRC]) begin
      irq_pin_next = 1'b0;
    end else begin
      irq_pin_next = mod_reg;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_pin <= 1'b1;
      o_irq_oe <= 1'b0;
      low_hist_reg <= 3'h0;
      o_irq_line_high <= 1'b1;
      o_irq_line_fault <= 1'b0;
    end else begin
      o_irq_pin <= irq_pin_next;
      o_irq_oe <= irq_oe_next;
      low_hist_reg <= {low_hist_reg[1:0], o_irq_oe && !o_irq_pin};
      o_irq_line_high <= irq_s;
      o_irq_line_fault <= !irq_s && !i_irq_mode[`ADCSP_IRQM_FUNC_BIT] && !(|low_hist_reg)
                          && !(o_irq_oe && !o_irq_pin);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mclk_pin <= 1'b0;
      o_mclk_oe <= 1'b0;
      o_spi_busy <= 1'b0;
      o_sample_tick <= 1'b0;
      o_result_tick <= 1'b0;
    end else begin
      o_mclk_pin <= ck.analog_master_clock_level;
      o_mclk_oe <= (i_clk_sel == `ADCSP_CLKSEL_OUT);
      o_spi_busy <= !cs_s;
      o_sample_tick <= ck.sample_tick;
      o_result_tick <= ck.rate_tick;
    end
  end

  sequence s_cs_idle;
    cs_s ##1 cs_s;
  endsequence
  sequence s_addr_miss;
    sck_rise && state_reg == SPI_CMD && bit_cnt_reg == 3'h1 && rx_full[1:0] != i_chip_addr;
  endsequence

  property p_frame_start;
    cs_fall |=> (state_reg == SPI_CMD && o_sdo_oe);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("select fall did not open frame");
  property p_cs_quiet;
    s_cs_idle |-> (!o_sdo_oe && !o_cmd_valid && !o_wr_valid);
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("activity while deselected");
  property p_sdo_on_fall;
    $changed(o_sdo) |-> ($past(sck_fall) || $past(cs_fall));
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("output moved off a falling edge");
  property p_cmd_on_rise;
    o_cmd_valid |-> ($past(sck_rise) && o_cmd == $past(rx_full));
  endproperty
  a_cmd_on_rise: assert property (p_cmd_on_rise) else $error("command not taken on rising edge");
  property p_write_release;
    (state_reg == SPI_WRITE || state_reg == SPI_DROP) |-> !o_sdo_oe;
  endproperty
  a_write_release: assert property (p_write_release) else $error("output driven in write or fast");
  property p_addr_miss;
    s_addr_miss |=> (!o_sdo_oe) [*3];
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("output driven after address miss");
  property p_read_no_write;
    (state_reg == SPI_READ && $past(state_reg) == SPI_READ) |-> !o_wr_valid;
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("input taken during read");
  property p_irq_low;
    (!i_irq_mode[`ADCSP_IRQM_FUNC_BIT] && |o_irq_pending) |=> (o_irq_oe && !o_irq_pin);
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("pending interrupt not driven low");
  property p_irq_idle;
    (!i_irq_mode[`ADCSP_IRQM_FUNC_BIT] && o_irq_pending == 4'h0)
      |=> (o_irq_pin && o_irq_oe == $past(i_irq_mode[`ADCSP_IRQM_IDLE_BIT]));
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("idle pin state wrong");
  property p_level_override;
    (i_irq_mode[`ADCSP_IRQM_FUNC_BIT] && (o_irq_pending[`ADCSP_IRQ_POR] || o_irq_pending[`ADCSP_IRQ_CRC]))
      |=> (o_irq_oe && !o_irq_pin);
  endproperty
  a_level_override: assert property (p_level_override) else $error("level interrupt not overriding");
  property p_drdy_set;
    ck.rate_tick |=> o_irq_pending[`ADCSP_IRQ_DRDY];
  endproperty
  a_drdy_set: assert property (p_drdy_set) else $error("data ready lost");
  property p_mclk_dir;
    o_mclk_oe == ($past(i_clk_sel) == `ADCSP_CLKSEL_OUT);
  endproperty
  a_mclk_dir: assert property (p_mclk_dir) else $error("clock pin direction wrong");
endmodule

/* File: adcsp_spi_master.sv */
// SPI master model: frames of 16 bits, modes 0,0 and 1,1.
// Assumes calls from the bench, paced by its reference clock.
`timescale 1ns/10ps
module adcsp_spi_master (
  input wire logic i_clk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  task automatic xfer(input logic cpol, input logic [15:0] tx, output logic [15:0] rx, output logic [15:0] oe);
    repeat (4) @(negedge i_clk);
    o_sck = cpol;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      // change on fall, sample before rise
      o_sck = 1'b0;
      o_sdi = tx[i];
      repeat (4) @(negedge i_clk);
      rx[i] = i_sdo;
      oe[i] = i_sdo_oe;
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
    end
    o_sck = cpol;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
  task automatic noise();
    repeat (16) begin
      @(negedge i_clk);
      o_sck = ~o_sck;
      o_sdi = ~o_sdi;
    end
  endtask
endmodule

/* File: adcsp_top_tb.sv */
// Bench for the serial port, interrupt pin and clock tree.
// Assumes adcsp_spi_master as the far side; pull-up on the interrupt pin.
`timescale 1ns/10ps
module adcsp_top_tb;
  logic clk = 0, arst_n = 0, mclk = 0, cont = 0, mod = 0, sdo_last = 0;
  logic [1:0] mode = 0, csel = 2'h2, pre = 0;
  logic [3:0] ev = 0, clr = 0, pend;
  logic [16:0] osr = 17'h3;
  logic cs_n, sck, sdi, sdo, sdo_oe, irq_o, irq_oe, mck_o, mck_oe, cmd_v, wr_v, line_hi, stk, rtk;
  logic rd_req, busy, fault, pull_dn = 0;
  int nrd = 0, nbusy = 0;
  logic [7:0] cmd, wr, cmd_l = 0, wr_l = 0;
  logic [15:0] sc = 0, sp = 0, rc = 0, rp = 0, rx, oe;
  int num_errors = 0, n_checks = 0, ncmd = 0, nwr = 0, cyc = 0;
  wire sdo_ln = sdo_oe ? sdo : ~sdo_last;
  wire irq_ln = irq_oe ? irq_o : !pull_dn;
  always #4 clk = ~clk;
  always #24 mclk = ~mclk;
  adcsp_spi_master m (.i_clk(clk), .i_sdo(sdo_ln), .i_sdo_oe(sdo_oe), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
  adcsp_top #(.INT_HALF(2)) DUT (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_sck(sck), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_irq_pin(irq_ln), .o_irq_pin(irq_o), .o_irq_oe(irq_oe),
    .i_mclk_pin(mck_oe ? mck_o : mclk), .o_mclk_pin(mck_o), .o_mclk_oe(mck_oe), .i_irq_mode(mode),
    .i_clk_sel(csel), .i_prescale_sel(pre), .i_osr(osr), .i_continuous(cont),
    .i_chip_addr(2'h1), .i_status(8'ha6), .i_rd_data(8'h3c), .i_mod_bit(mod),
    .i_por_event(ev[2]), .i_crc_event(ev[1]), .i_aux_event(ev[3]), .i_irq_clr(clr),
    .o_cmd(cmd), .o_cmd_valid(cmd_v), .o_wr_data(wr), .o_wr_valid(wr_v), .o_rd_req(rd_req),
    .o_spi_busy(busy), .o_irq_pending(pend), .o_irq_line_high(line_hi), .o_irq_line_fault(fault),
    .o_sample_tick(stk), .o_result_tick(rtk));
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sc <= stk ? 16'h1 : sc + 16'h1;
    rc <= rtk ? 16'h1 : rc + 16'h1;
    if (stk) sp <= sc;
    if (rtk) rp <= rc;
    if (sdo_oe) sdo_last <= sdo;
    if (cmd_v) ncmd <= ncmd + 1;
    if (cmd_v) cmd_l <= cmd;
    if (wr_v) nwr <= nwr + 1;
    if (wr_v) wr_l <= wr;
    if (rd_req) nrd <= nrd + 1;
    if (busy) nbusy <= nbusy + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic pul(input logic [3:0] e, input logic [3:0] c);
    @(negedge clk);
    ev = e;
    clr = c;
    @(negedge clk);
    ev = 0;
    clr = 0;
    repeat (6) @(negedge clk);
  endtask
  task automatic wt(input bit r);
    for (int n = 0; n < 2000 && (r ? rtk : stk) !== 1'b1; n++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic t_read();
    for (int i = 0; i < 4; i++) begin
      m.xfer(i[0], {2'h1, 4'h5, i[1], 1'b1, 8'hc3}, rx, oe);
      chk("rd bits", rx, 16'ha63c);
      chk("rd oe", oe, 16'hffff);
      chk("rd cmd", cmd_l, {2'h1, 4'h5, i[1], 1'b1});
      chk("rd wr", nwr, 0);
    end
    chk("rd req", nrd, 6);
    chk("busy seen", nbusy > 0, 1);
  endtask
  task automatic t_wr();
    int n;
    m.xfer(0, 16'h429e, rx, oe);
    chk("wr oe", oe, 16'hff00);
    chk("wr data", wr_l, 8'h9e);
    m.xfer(1, 16'h4000, rx, oe);
    chk("fast oe", oe, 16'hff00);
    m.xfer(0, 16'h8255, rx, oe);
    chk("miss oe", oe, 16'hc000);
    chk("miss wr", nwr, 1);
    n = ncmd;
    m.noise();
    repeat (6) @(negedge clk);
    chk("idle cmd", ncmd, n);
    chk("idle oe", sdo_oe, 0);
    chk("idle busy", busy, 0);
  endtask
  task automatic t_irq();
    for (int k = 1; k < 4; k++) begin
      mode = 2'h0;
      pul(4'h1 << k, 0);
      chk("pend", pend[k], 1);
      chk("irq low", irq_ln, 0);
      pul(0, 4'h1 << k);
      chk("idle oe", irq_oe, 0);
      chk("sensed", line_hi, 1);
      chk("no fault", fault, 0);
      pull_dn = 1;
      repeat (6) @(negedge clk);
      chk("sensed low", line_hi, 0);
      chk("fault", fault, 1);
      pull_dn = 0;
      repeat (6) @(negedge clk);
      mode = 2'h1;
      pul(0, 0);
      chk("idle high", {irq_oe, irq_o}, 2'h3);
    end
  endtask
  task automatic t_bits();
    mode = 2'h2;
    for (int b = 0; b < 2; b++) begin
      mod = b[0];
      wt(0);
      wt(0);
      chk("bitstream", irq_ln, b[0]);
    end
    for (int k = 1; k < 3; k++) begin
      pul(4'h1 << k, 0);
      wt(0);
      chk("lock", irq_ln, 0);
      pul(0, 4'h1 << k);
      wt(0);
      wt(0);
      chk("unlock", irq_ln, 1);
    end
  endtask
  task automatic t_clk();
    for (int s = 0; s < 4; s++) begin
      pre = s[1:0];
      repeat (3) wt(0);
      chk("sample", sp, 16'h10 << s);
    end
    csel = 2'h3;
    cont = 1;
    mode = 2'h0;
    repeat (3) wt(1);
    chk("drdy", {pend[0], irq_ln}, 2'h2);
    chk("result", rp, 16'h180);
    chk("clk out", mck_oe, 1);
    csel = 2'h0;
    pre = 2'h0;
    repeat (3) wt(0);
    chk("ext", sp, 16'h18);
    chk("clk in", mck_oe, 0);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1;
    repeat (4) @(negedge clk);
    t_read();
    t_wr();
    t_irq();
    t_bits();
    t_clk();
    conclude();
  end
endmodule
